// file: common/rsc_pkg.sv
// Purpose: shared constants and types for the reset and irq pin conditioner
// Assumes: 32-bit apb data, one word per register, byte addresses
// Notes:   all offsets, fields, reset values and counts live here
package rsc_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] PUDR_OFF   = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [7:0] MASK_OFF   = 8'h0C;
  localparam logic [7:0] STATE_OFF  = 8'h10;

  // field positions
  localparam int IRQ_A_BIT   = 0;
  localparam int IRQ_B_BIT   = 1;
  localparam int RSTEV_BIT   = 2;
  localparam int PU_RST_BIT  = 0;
  localparam int PU_IRQ_BIT  = 1;
  localparam int ST_CORE_BIT = 0;
  localparam int ST_DBG_BIT  = 1;
  localparam int ST_LP_BIT   = 2;

  localparam int NUM_IRQ  = 2;
  localparam int STAT_W   = 3;

  // reset values
  localparam logic [1:0]        CTRL_RST = 2'h0;
  localparam logic [1:0]        PUDR_RST = 2'h0;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

  // internal clocks between pin release and core release
  localparam int         REL_CNT_W     = 6;
  localparam logic [5:0] REL_CYCLES    = 6'h20;
  localparam logic [5:0] REL_LAST      = 6'h1F;

  typedef enum logic [1:0] {
    RSC_RST_HOLD  = 2'b00,
    RSC_RST_COUNT = 2'b01,
    RSC_RST_RUN   = 2'b10
  } rsc_rst_state_e;

  // per input: 1 selects falling edge, 0 selects active low level
  typedef struct packed {
    logic [1:0] trig_edge;
  } rsc_ctrl_s;

  typedef struct packed {
    logic irq_pu_dis;
    logic rst_pu_dis;
  } rsc_pudr_s;

endpackage

// file: hw/rsc_reset_irq.sv
// Purpose: reset sequencing and external irq pin conditioning with apb regs
// Assumes: all pins synchronous to core_clk_i; srst_i is power-on reset
// Notes:   zero wait apb slave, pready one cycle after setup
`timescale 1ns/1ps

module rsc_reset_irq (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ext_rst_n_i,
  input  wire logic        trst_n_i,
  input  wire logic        low_power_i,
  input  wire logic        ext_irq_a_i,
  input  wire logic        ext_irq_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             core_rst_o,
  output logic             reset_state_out_o,
  output logic             dbg_rst_o,
  output logic             rst_pullup_off_o,
  output logic             irq_pullup_off_o,
  output logic      [1:0]  svc_req_o,
  output logic             irq_o
);

  rsc_pkg::rsc_rst_state_e             rst_state_reg;
  rsc_pkg::rsc_rst_state_e             rst_state_next;
  logic [rsc_pkg::REL_CNT_W-1:0]       rel_cnt_reg;
  logic                                core_rst_reg;
  logic                                core_rst_next;
  logic                                dbg_rst_reg;
  rsc_pkg::rsc_ctrl_s                  ctrl_reg;
  rsc_pkg::rsc_pudr_s                  pudr_reg;
  logic [rsc_pkg::STAT_W-1:0]          stat_reg;
  logic [rsc_pkg::STAT_W-1:0]          stat_set;
  logic [rsc_pkg::STAT_W-1:0]          stat_clr;
  logic [rsc_pkg::STAT_W-1:0]          mask_reg;
  logic                                irq_reg;
  logic [31:0]                         prdata_reg;
  logic                                pready_reg;
  logic                                pslverr_reg;
  logic [31:0]                         rd_val;
  logic                                rd_hit;
  logic                                setup_ph;
  logic                                wr_done;
  logic [1:0]                          pin_raw;
  logic [1:0]                          irq_meta_reg;
  logic [1:0]                          irq_sync_reg;
  logic [1:0]                          src_prev_reg;
  logic [1:0]                          svc_reg;
  logic [1:0]                          irq_src;
  logic [1:0]                          irq_evt;

  assign pin_raw  = {ext_irq_b_i, ext_irq_a_i};
  assign setup_ph = psel_i && !penable_i;
  assign wr_done  = psel_i && penable_i && pready_reg && pwrite_i;

  // reset sequencer
  always_comb
  begin
    rst_state_next = rst_state_reg;
    case (rst_state_reg)
      rsc_pkg::RSC_RST_HOLD:
      begin
        if (ext_rst_n_i)
          rst_state_next = rsc_pkg::RSC_RST_COUNT;
      end
      rsc_pkg::RSC_RST_COUNT:
      begin
        if (!ext_rst_n_i)
          rst_state_next = rsc_pkg::RSC_RST_HOLD;
        else if (rel_cnt_reg == rsc_pkg::REL_LAST)
          rst_state_next = rsc_pkg::RSC_RST_RUN;
      end
      rsc_pkg::RSC_RST_RUN:
      begin
        if (!ext_rst_n_i)
          rst_state_next = rsc_pkg::RSC_RST_HOLD;
      end
      default:
        rst_state_next = rsc_pkg::RSC_RST_HOLD;
    endcase
    if (srst_i)
      rst_state_next = rsc_pkg::RSC_RST_HOLD;
  end

  // released only on the clock edge that enters run
  assign core_rst_next = (rst_state_next != rsc_pkg::RSC_RST_RUN);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      rst_state_reg <= rsc_pkg::RSC_RST_HOLD;
    else
      rst_state_reg <= rst_state_next;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || rst_state_reg != rsc_pkg::RSC_RST_COUNT)
      rel_cnt_reg <= '0;
    else
      rel_cnt_reg <= rel_cnt_reg + 6'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      core_rst_reg <= 1'b1;
    else
      core_rst_reg <= core_rst_next;
  end

  // debug logic follows power-on and test reset only, never the pin
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      dbg_rst_reg <= 1'b1;
    else
      dbg_rst_reg <= !trst_n_i;
  end

  // irq conditioning, one lane per pin
  genvar gi;
  generate
    for (gi = 0; gi < rsc_pkg::NUM_IRQ; gi++)
    begin : g_irq
      always_ff @(posedge core_clk_i)
      begin
        if (srst_i)
        begin
          irq_meta_reg[gi] <= 1'b1;
          irq_sync_reg[gi] <= 1'b1;
        end
        else
        begin
          irq_meta_reg[gi] <= pin_raw[gi];
          irq_sync_reg[gi] <= irq_meta_reg[gi];
        end
      end

      // stop and wait have no usable sync path, so take the pin itself
      assign irq_src[gi] = low_power_i ? pin_raw[gi]
                                       : irq_sync_reg[gi];
      assign irq_evt[gi] = ctrl_reg.trig_edge[gi]
                         ? (src_prev_reg[gi] && !irq_src[gi])
                         : !irq_src[gi];
      always_ff @(posedge core_clk_i)
      begin
        if (srst_i)
        begin
          src_prev_reg[gi] <= 1'b1;
          svc_reg[gi]      <= 1'b0;
        end
        else
        begin
          src_prev_reg[gi] <= irq_src[gi];
          svc_reg[gi]      <= irq_evt[gi];
        end
      end
    end
  endgenerate

  // config is initialised by power-on reset and by core reset, not by test reset
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || core_rst_reg)
      ctrl_reg <= rsc_pkg::CTRL_RST;
    else if (wr_done && paddr_i == rsc_pkg::CTRL_OFF)
      ctrl_reg <= pwdata_i[1:0];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || core_rst_reg)
      pudr_reg <= rsc_pkg::PUDR_RST;
    else if (wr_done && paddr_i == rsc_pkg::PUDR_OFF)
      pudr_reg <= pwdata_i[1:0];
  end

  // status survives pin reset so software can see it happened
  assign stat_set = {!ext_rst_n_i, irq_evt};
  assign stat_clr = (wr_done && paddr_i == rsc_pkg::STAT_OFF)
                  ? pwdata_i[rsc_pkg::STAT_W-1:0] : '0;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      stat_reg <= rsc_pkg::STAT_RST;
    else
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      mask_reg <= rsc_pkg::MASK_RST;
    else if (wr_done && paddr_i == rsc_pkg::MASK_OFF)
      mask_reg <= pwdata_i[rsc_pkg::STAT_W-1:0];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(((stat_reg & ~stat_clr) | stat_set) & mask_reg);
  end

  // apb read mux
  always_comb
  begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr_i)
      rsc_pkg::CTRL_OFF:
        rd_val[1:0] = ctrl_reg;
      rsc_pkg::PUDR_OFF:
        rd_val[1:0] = pudr_reg;
      rsc_pkg::STAT_OFF:
        rd_val[rsc_pkg::STAT_W-1:0] = stat_reg;
      rsc_pkg::MASK_OFF:
        rd_val[rsc_pkg::STAT_W-1:0] = mask_reg;
      rsc_pkg::STATE_OFF:
      begin
        rd_val[rsc_pkg::ST_CORE_BIT] = core_rst_reg;
        rd_val[rsc_pkg::ST_DBG_BIT]  = dbg_rst_reg;
        rd_val[rsc_pkg::ST_LP_BIT]   = low_power_i;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  // answer prepared in setup so the access phase needs no wait state
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
    else if (setup_ph)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !rd_hit;
      prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_val;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata_o          = prdata_reg;
  assign pready_o          = pready_reg;
  assign pslverr_o         = pslverr_reg;
  assign core_rst_o        = core_rst_reg;
  assign reset_state_out_o = core_rst_reg;
  assign dbg_rst_o         = dbg_rst_reg;
  assign rst_pullup_off_o  = pudr_reg.rst_pu_dis;
  assign irq_pullup_off_o  = pudr_reg.irq_pu_dis;
  assign svc_req_o         = svc_reg;
  assign irq_o             = irq_reg;

  // checks
  property p_pin_hold;
    @(posedge core_clk_i) disable iff (srst_i)
    !ext_rst_n_i |=> core_rst_o [*2];
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("core reset dropped while pin low");
  property p_release_delay;
    @(posedge core_clk_i) disable iff (srst_i)
    (ext_rst_n_i && $rose(ext_rst_n_i)) ##1 ext_rst_n_i [*8]
      |-> core_rst_o;
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("core reset released too early");
  property p_release_end;
    @(posedge core_clk_i) disable iff (srst_i)
    (rst_state_reg == rsc_pkg::RSC_RST_COUNT &&
     rel_cnt_reg == rsc_pkg::REL_LAST && ext_rst_n_i)
      |=> !core_rst_o && !reset_state_out_o;
  endproperty
  a_release_end: assert property (p_release_end)
    else $error("core reset not released after count");
  property p_por;
    @(posedge core_clk_i)
    srst_i |=> core_rst_o && dbg_rst_o;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on reset not applied");
  // registers are unknown before the first power-on edge
  property p_mirror;
    @(posedge core_clk_i) disable iff (srst_i)
    reset_state_out_o == (rst_state_reg != rsc_pkg::RSC_RST_RUN);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("reset state output differs from internal reset");
  property p_dbg_keep;
    @(posedge core_clk_i) disable iff (srst_i)
    (trst_n_i && !ext_rst_n_i) |=> !dbg_rst_o;
  endproperty
  a_dbg_keep: assert property (p_dbg_keep)
    else $error("debug reset asserted by pin reset");
  property p_rst_pu;
    @(posedge core_clk_i) disable iff (srst_i || core_rst_o)
    (wr_done && paddr_i == rsc_pkg::PUDR_OFF && pwdata_i[0])
      |=> rst_pullup_off_o;
  endproperty
  a_rst_pu: assert property (p_rst_pu)
    else $error("reset pull-up not disabled");
  property p_irq_pu;
    @(posedge core_clk_i) disable iff (srst_i || core_rst_o)
    (wr_done && paddr_i == rsc_pkg::PUDR_OFF && !pwdata_i[1])
      |=> !irq_pullup_off_o;
  endproperty
  a_irq_pu: assert property (p_irq_pu)
    else $error("irq pull-up disable wrong");
  property p_lp_direct;
    @(posedge core_clk_i) disable iff (srst_i)
    (low_power_i && !ext_irq_a_i && !ctrl_reg.trig_edge[0])
      |=> svc_req_o[0];
  endproperty
  a_lp_direct: assert property (p_lp_direct)
    else $error("low power irq not taken at once");
  property p_sync_path;
    @(posedge core_clk_i) disable iff (srst_i)
    (!low_power_i && !ext_irq_b_i && !ctrl_reg.trig_edge[1]) [*3]
      |=> svc_req_o[1];
  endproperty
  a_sync_path: assert property (p_sync_path)
    else $error("synchronised irq b missing");
  property p_edge;
    @(posedge core_clk_i) disable iff (srst_i)
    (low_power_i && ctrl_reg.trig_edge[0] && $fell(ext_irq_a_i))
      ##1 (low_power_i && !ext_irq_a_i)
      |-> svc_req_o[0] ##1 !svc_req_o[0];
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge mode request not a single pulse");

endmodule

// file: tb/rsc_board_model.sv
// Purpose: board side of the reset and irq pins
// Assumes: tasks are called just after a rising clock edge
// Notes:   pins idle high, as the pull-ups would leave them
`timescale 1ns/1ps

module rsc_board_model (
  output logic ext_rst_n_o,
  output logic trst_n_o,
  output logic ext_irq_a_n_o,
  output logic ext_irq_b_n_o
);
  initial
  begin
    ext_rst_n_o   = 1'b1;
    trst_n_o      = 1'b1;
    ext_irq_a_n_o = 1'b1;
    ext_irq_b_n_o = 1'b1;
  end

  // full reset drops both lines; debug survival drops the pin only
  task automatic drive_reset(input logic rst_n, input logic trst_n);
    ext_rst_n_o <= rst_n;
    trst_n_o    <= trst_n;
  endtask

  task automatic set_irq(input logic a_n, input logic b_n);
    ext_irq_a_n_o <= a_n;
    ext_irq_b_n_o <= b_n;
  endtask
endmodule

// file: tb/rsc_reset_irq_test.sv
// Purpose: self-checking bench for the reset and irq pin conditioner
// Assumes: apb slave answers with pready, bench waits up to 16 edges
// Notes:   latencies are counted in edges from the pin change, or from power-on reset release for the first one
`timescale 1ns/1ps

module rsc_reset_irq_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        low_power = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        core_rst_o;
  logic        reset_state_out_o;
  logic        dbg_rst_o;
  logic        rst_pu_off;
  logic        irq_pu_off;
  logic [1:0]  svc_req_o;
  logic        irq_o;
  logic        rst_n;
  logic        trst_n;
  logic        irq_a_n;
  logic        irq_b_n;
  int          err_count = 0;
  int          check_count = 0;
  int          n;

  always #2.5 clk = ~clk;

  rsc_board_model board (
    .ext_rst_n_o   (rst_n),
    .trst_n_o      (trst_n),
    .ext_irq_a_n_o (irq_a_n),
    .ext_irq_b_n_o (irq_b_n)
  );

  rsc_reset_irq dut (
    .core_clk_i        (clk),
    .srst_i            (srst),
    .ext_rst_n_i       (rst_n),
    .trst_n_i          (trst_n),
    .low_power_i       (low_power),
    .ext_irq_a_i       (irq_a_n),
    .ext_irq_b_i       (irq_b_n),
    .psel_i            (psel),
    .penable_i         (penable),
    .pwrite_i          (pwrite),
    .paddr_i           (paddr),
    .pwdata_i          (pwdata),
    .prdata_o          (prdata_o),
    .pready_o          (pready_o),
    .pslverr_o         (pslverr_o),
    .core_rst_o        (core_rst_o),
    .reset_state_out_o (reset_state_out_o),
    .dbg_rst_o         (dbg_rst_o),
    .rst_pullup_off_o  (rst_pu_off),
    .irq_pullup_off_o  (irq_pu_off),
    .svc_req_o         (svc_req_o),
    .irq_o             (irq_o)
  );

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] e,
                      input logic e_err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready_o === 1'b1)
        break;
    end
    chk("pready", 32'h1, {31'h0, pready_o});
    chk("pslverr", {31'h0, e_err}, {31'h0, pslverr_o});
    if (!wr)
      chk("prdata", e, prdata_o);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts edges until the selected output reaches its awaited level
  task automatic wait_for(input int sel, output int cnt);
    cnt = 0;
    repeat (100)
    begin
      @(posedge clk);
      cnt++;
      #1;
      if (sel == 0)
        chk("rst_state_out", {31'h0, core_rst_o}, {31'h0, reset_state_out_o});
      if ((sel == 0 && core_rst_o === 1'b0) ||
          (sel == 1 && svc_req_o[0] === 1'b1) ||
          (sel == 2 && svc_req_o[1] === 1'b1))
        break;
    end
  endtask

  initial
  begin
    #100000;
    err_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("core_rst_por", 32'h1, {31'h0, core_rst_o});
    chk("dbg_rst_por", 32'h1, {31'h0, dbg_rst_o});
    wait_for(0, n);
    chk("por_release", rsc_pkg::REL_CYCLES + 32'h1, n);
    $display("test power_on done");

    board.drive_reset(1'b0, 1'b1);
    xfer(1'b1, rsc_pkg::CTRL_OFF, 32'h3, 32'h0, 1'b0);
    #1;
    chk("core_rst_pin", 32'h1, {31'h0, core_rst_o});
    chk("dbg_kept", 32'h0, {31'h0, dbg_rst_o});
    board.drive_reset(1'b1, 1'b1);
    wait_for(0, n);
    chk("pin_release", rsc_pkg::REL_CYCLES + 32'h1, n);
    xfer(1'b0, rsc_pkg::CTRL_OFF, 0, 32'h0, 1'b0);
    xfer(1'b0, rsc_pkg::STAT_OFF, 0, 32'h4, 1'b0);
    board.drive_reset(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("dbg_full", 32'h1, {31'h0, dbg_rst_o});
    board.drive_reset(1'b1, 1'b1);
    wait_for(0, n);
    chk("full_release", rsc_pkg::REL_CYCLES + 32'h1, n);
    xfer(1'b1, rsc_pkg::STAT_OFF, 32'h4, 0, 1'b0);
    xfer(1'b0, rsc_pkg::STAT_OFF, 0, 32'h0, 1'b0);
    $display("test pin_reset done");

    for (int v = 1; v < 3; v++)
    begin
      xfer(1'b1, rsc_pkg::PUDR_OFF, v, 0, 1'b0);
      #1;
      chk("rst_pu", v & 1, {31'h0, rst_pu_off});
      chk("irq_pu", v >> 1, {31'h0, irq_pu_off});
    end
    $display("test pullup done");

    xfer(1'b1, rsc_pkg::MASK_OFF, 32'h1, 0, 1'b0);
    for (int lp = 0; lp < 2; lp++)
    begin
      low_power <= lp[0];
      xfer(1'b0, rsc_pkg::STATE_OFF, 0, lp << 2, 1'b0);
      board.set_irq(1'b0, 1'b0);
      wait_for(1, n);
      chk("svc_lat", lp ? 1 : 3, n);
      repeat (4) @(posedge clk);
      #1;
      chk("svc_level", 32'h3, {30'h0, svc_req_o});
      chk("irq_set", 32'h1, {31'h0, irq_o});
      board.set_irq(1'b1, 1'b1);
      xfer(1'b0, rsc_pkg::STAT_OFF, 0, 32'h3, 1'b0);
      xfer(1'b1, rsc_pkg::STAT_OFF, 32'h3, 0, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk("irq_clr", 32'h0, {31'h0, irq_o});
    end
    $display("test irq_level done");

    low_power <= 1'b0;
    xfer(1'b1, rsc_pkg::CTRL_OFF, 32'h2, 0, 1'b0);
    board.set_irq(1'b0, 1'b0);
    wait_for(2, n);
    chk("edge_lat", 32'd3, n);
    chk("svc_both", 32'h3, {30'h0, svc_req_o});
    @(posedge clk);
    #1;
    chk("edge_pulse", 32'h1, {30'h0, svc_req_o});
    xfer(1'b0, rsc_pkg::STAT_OFF, 0, 32'h3, 1'b0);
    xfer(1'b1, rsc_pkg::MASK_OFF, 32'h0, 0, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    board.set_irq(1'b1, 1'b1);
    xfer(1'b1, rsc_pkg::STAT_OFF, 32'h3, 0, 1'b0);
    xfer(1'b0, rsc_pkg::STAT_OFF, 0, 32'h0, 1'b0);
    xfer(1'b1, rsc_pkg::CTRL_OFF, 32'h3, 0, 1'b0);
    low_power <= 1'b1;
    board.set_irq(1'b0, 1'b1);
    wait_for(1, n);
    chk("lp_edge_lat", 32'h1, n);
    @(posedge clk);
    #1;
    chk("lp_edge_pulse", 32'h0, {30'h0, svc_req_o});
    board.set_irq(1'b1, 1'b1);
    xfer(1'b0, rsc_pkg::STAT_OFF, 0, 32'h1, 1'b0);
    xfer(1'b1, rsc_pkg::STAT_OFF, 32'h1, 0, 1'b0);
    low_power <= 1'b0;
    $display("test irq_edge done");

    xfer(1'b0, 8'h14, 0, 32'h0, 1'b1);
    xfer(1'b1, 8'h18, 32'h7, 0, 1'b1);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule
